/* File: core/nmer_regs.svh */
// Constants for the NAND multi-erase host controller
`ifndef NMER_REGS_SVH
`define NMER_REGS_SVH
`define NMER_CMD_ERASE_SETUP 8'h60
`define NMER_CMD_ERASE_GO    8'hD0
`define NMER_CMD_STATUS1     8'h70
`define NMER_CMD_STATUS2     8'h71
`define NMER_CMD_RESET       8'hFF
`define NMER_CMD_ID1         8'h90
`define NMER_CMD_ID2         8'h91
`define NMER_OFF_CTRL        4'h0
`define NMER_OFF_BLK0        4'h1
`define NMER_OFF_BLK1        4'h2
`define NMER_OFF_BLK2        4'h3
`define NMER_OFF_BLK3        4'h4
`define NMER_OFF_STAT        4'h5
`define NMER_OFF_RESULT      4'h6
`define NMER_OFF_ID          4'h7
`define NMER_OP_ERASE        3'h1
`define NMER_OP_STATUS       3'h2
`define NMER_OP_RESET        3'h3
`define NMER_OP_ID1          3'h4
`define NMER_OP_ID2          3'h5
`define NMER_POWERUP_US      200
`define NMER_CLK_MHZ         100
`define NMER_POWERUP_CYC     (`NMER_POWERUP_US * `NMER_CLK_MHZ)
`define NMER_STROBE_CYC      4'h3
`define NMER_DISTRICTS       4
`define NMER_BLOCK_BITS      13
`endif

/* File: core/nmer_pkg.sv */
// Types for the NAND multi-erase host controller
package nmer_pkg;
  typedef enum logic [3:0] {
    NMER_S_POWER = 4'h0,
    NMER_S_IDLE  = 4'h1,
    NMER_S_CMD   = 4'h2,
    NMER_S_ADDR  = 4'h3,
    NMER_S_NEXT  = 4'h4,
    NMER_S_WAIT  = 4'h5,
    NMER_S_READ  = 4'h6,
    NMER_S_DONE  = 4'h7
  } nmer_state_type;
  typedef struct packed {
    logic       ce_n;
    logic       cle;
    logic       ale;
    logic       we_n;
    logic       read_strobe_n;
    logic       wp_n;
    logic [7:0] dq_out;
    logic       dq_oe;
  } nmer_pins_type;
endpackage

/* File: core/nmer_host.sv */
// Host controller that drives multi-block erase, status, reset and ID
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ps
`include "nmer_regs.svh"
module nmer_host
  import nmer_pkg::*;
(
  input  wire logic        clk_sys,        // 100 MHz clock
  input  wire logic        rst_n,          // Async reset, active low
  input  wire logic [3:0]  addr,           // Register address
  input  wire logic [31:0] wdata,          // Write data
  input  wire logic        wr,             // Write strobe
  input  wire logic        rd,             // Read strobe
  output logic      [31:0] rdata,          // Read data, cycle after rd
  input  wire logic [7:0]  dq_in,          // Flash data bus input
  input  wire logic        ready_busy_n,   // Flash ready, low when busy
  output logic             ce_n,           // Chip enable, active low
  output logic             cle,            // Command latch enable
  output logic             ale,            // Address latch enable
  output logic             we_n,           // Write strobe to flash
  output logic             read_strobe_n,  // Read strobe to flash
  output logic             wp_n,           // Write protect, active low
  output logic      [7:0]  dq_out,         // Flash data bus output
  output logic             dq_oe           // Data bus drive enable
);
  localparam int CNT_W = 15;
  nmer_state_type state_ff, nxt_state;
  nmer_pins_type  pins_ff, nxt_pins;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [2:0]  op_ff, nxt_op;
  logic [3:0]  sel_ff, nxt_sel;
  logic [1:0]  idx_ff, nxt_idx;
  logic [1:0]  byte_ff, nxt_byte;
  logic [1:0]  acnt_ff, nxt_acnt;
  logic [1:0]  step_ff, nxt_step;
  logic [7:0]  result_ff, nxt_result;
  logic [15:0] id_ff, nxt_id;
  logic        done_ff, nxt_done;
  logic        err_ff, nxt_err;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [12:0] blk_ff [0:3];
  logic [7:0]  dq_s1_ff, dq_s2_ff;
  logic        rb_s1_ff, rb_s2_ff;
  logic [7:0]  cmd;
  logic [7:0]  abyte;
  logic [12:0] cur_blk;
  logic        ctrl_wr;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dq_s1_ff <= 8'h00;
      dq_s2_ff <= 8'h00;
      rb_s1_ff <= 1'b0;
      rb_s2_ff <= 1'b0;
    end else begin
      dq_s1_ff <= dq_in;
      dq_s2_ff <= dq_s1_ff;
      rb_s1_ff <= ready_busy_n;
      rb_s2_ff <= rb_s1_ff;
    end
  end

  // Block address registers; district of an entry is its own index
  genvar g;
  generate
    for (g = 0; g < `NMER_DISTRICTS; g++) begin : g_blk
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          blk_ff[g] <= 13'h0000;
        end else if (wr && addr == (`NMER_OFF_BLK0 + 4'(g))) begin
          blk_ff[g] <= {wdata[10:0], 2'(g)};
        end
      end
    end
  endgenerate

  assign ctrl_wr = wr && addr == `NMER_OFF_CTRL;
  assign cur_blk = blk_ff[idx_ff];
  // Three row cycles; column cycle is sent only for ID reads
  always_comb begin
    abyte = 8'h00;
    case (acnt_ff)
      2'h0: abyte = {cur_blk[2:0], 5'h00};
      2'h1: abyte = cur_blk[10:3];
      default: abyte = {6'h00, cur_blk[12:11]};
    endcase
  end

  always_comb begin
    cmd = `NMER_CMD_RESET;
    case (op_ff)
      `NMER_OP_ERASE:  cmd = (step_ff == 2'h0) ? `NMER_CMD_ERASE_SETUP
                                               : `NMER_CMD_ERASE_GO;
      `NMER_OP_STATUS: cmd = `NMER_CMD_STATUS2;
      `NMER_OP_ID1:    cmd = `NMER_CMD_ID1;
      `NMER_OP_ID2:    cmd = `NMER_CMD_ID2;
      default:         cmd = `NMER_CMD_RESET;
    endcase
  end

  always_comb begin
    nxt_state  = state_ff;
    nxt_pins   = pins_ff;
    nxt_cnt    = cnt_ff;
    nxt_op     = op_ff;
    nxt_sel    = sel_ff;
    nxt_idx    = idx_ff;
    nxt_byte   = byte_ff;
    nxt_acnt   = acnt_ff;
    nxt_step   = step_ff;
    nxt_result = result_ff;
    nxt_id     = id_ff;
    nxt_done   = done_ff;
    nxt_err    = err_ff;
    nxt_rdata  = 32'h0000_0000;
    if (rd) begin
      if (addr == `NMER_OFF_STAT) begin
        nxt_rdata = {28'h0, err_ff, done_ff, rb_s2_ff,
                     state_ff != NMER_S_IDLE};
      end else if (addr == `NMER_OFF_RESULT) begin
        nxt_rdata = {24'h0, result_ff};
      end else if (addr == `NMER_OFF_ID) begin
        nxt_rdata = {16'h0, id_ff};
      end else if (addr == `NMER_OFF_CTRL) begin
        nxt_rdata = {25'h0, sel_ff, op_ff};
      end
    end
    if (ctrl_wr && wdata[2:0] == `NMER_OP_RESET &&
        state_ff != NMER_S_POWER) begin
      // Reset is allowed in every state except the power-up wait, even mid-operation
      nxt_op    = `NMER_OP_RESET;
      nxt_state = NMER_S_CMD;
      nxt_cnt   = '0;
      nxt_done  = 1'b0;
      nxt_pins.we_n = 1'b1;
      nxt_pins.read_strobe_n = 1'b1;
    end else begin
      case (state_ff)
        NMER_S_POWER: begin
          nxt_cnt = cnt_ff + 1'b1;
          if (cnt_ff == CNT_W'(`NMER_POWERUP_CYC - 1)) begin
            nxt_state   = NMER_S_IDLE;
            nxt_pins.wp_n = 1'b1;
          end
        end
        NMER_S_IDLE: begin
          nxt_pins.ce_n = 1'b1;
          if (ctrl_wr) begin
            nxt_op   = wdata[2:0];
            nxt_sel  = wdata[6:3];
            nxt_done = 1'b0;
            nxt_err  = 1'b0;
            nxt_step = 2'h0;
            nxt_byte = 2'h0;
            nxt_cnt  = '0;
            if (wdata[2:0] == `NMER_OP_ERASE && wdata[6:3] == 4'h0) begin
              nxt_err = 1'b1;
            end else if (wdata[2:0] == `NMER_OP_ERASE) begin
              nxt_idx   = 2'h0;
              nxt_state = wdata[3] ? NMER_S_CMD : NMER_S_NEXT;
            end else if (wdata[2:0] >= `NMER_OP_STATUS &&
                         wdata[2:0] <= `NMER_OP_ID2) begin
              nxt_state = NMER_S_CMD;
            end else begin
              nxt_err = 1'b1;
            end
          end
        end
        NMER_S_CMD: begin
          nxt_pins.ce_n = 1'b0;
          nxt_pins.cle  = 1'b1;
          nxt_pins.ale  = 1'b0;
          nxt_pins.dq_out = cmd;
          nxt_pins.dq_oe  = 1'b1;
          nxt_pins.we_n   = (cnt_ff == 4'h0);
          nxt_cnt = cnt_ff + 1'b1;
          if (cnt_ff == CNT_W'(`NMER_STROBE_CYC)) begin
            nxt_pins.we_n = 1'b1;
            nxt_cnt  = '0;
            nxt_acnt = 2'h0;
            if (op_ff == `NMER_OP_ERASE && step_ff == 2'h0) begin
              nxt_state = NMER_S_ADDR;
            end else if (op_ff == `NMER_OP_ID1 || op_ff == `NMER_OP_ID2) begin
              nxt_acnt  = 2'h3;
              nxt_state = NMER_S_ADDR;
            end else if (op_ff == `NMER_OP_STATUS) begin
              nxt_state = NMER_S_READ;
            end else begin
              nxt_state = NMER_S_WAIT;
            end
          end
        end
        NMER_S_ADDR: begin
          nxt_pins.cle = 1'b0;
          nxt_pins.ale = 1'b1;
          nxt_pins.dq_out = (acnt_ff == 2'h3) ? 8'h00 : abyte;
          nxt_pins.we_n   = (cnt_ff == 4'h0);
          nxt_cnt = cnt_ff + 1'b1;
          if (cnt_ff == CNT_W'(`NMER_STROBE_CYC)) begin
            nxt_pins.we_n = 1'b1;
            nxt_cnt  = '0;
            nxt_acnt = acnt_ff + 1'b1;
            // Latch stays high through the closing strobe edge
            if (acnt_ff == 2'h3) begin
              nxt_state = NMER_S_READ;
            end else if (acnt_ff == 2'h2) begin
              nxt_sel   = sel_ff & ~(4'h1 << idx_ff);
              nxt_state = NMER_S_NEXT;
            end
          end
        end
        NMER_S_NEXT: begin
          // Walk the selected districts; one address set per district
          nxt_pins.ale = 1'b0;
          if (sel_ff == 4'h0) begin
            nxt_step  = 2'h1;
            nxt_state = NMER_S_CMD;
          end else if (sel_ff[idx_ff]) begin
            nxt_state = NMER_S_CMD;
          end else begin
            nxt_idx = idx_ff + 1'b1;
          end
        end
        NMER_S_WAIT: begin
          nxt_pins.cle   = 1'b0;
          nxt_pins.dq_oe = 1'b0;
          nxt_cnt = (cnt_ff == CNT_W'(`NMER_STROBE_CYC)) ? cnt_ff
                                                         : cnt_ff + 1'b1;
          // Ready/busy needs time to fall after the command
          if (cnt_ff == CNT_W'(`NMER_STROBE_CYC) && rb_s2_ff) begin
            nxt_cnt  = '0;
            nxt_op   = `NMER_OP_STATUS;
            nxt_state = NMER_S_CMD;
          end
        end
        NMER_S_READ: begin
          nxt_pins.cle   = 1'b0;
          nxt_pins.ale   = 1'b0;
          nxt_pins.dq_oe = 1'b0;
          nxt_pins.read_strobe_n = (cnt_ff >= CNT_W'(2));
          nxt_cnt = cnt_ff + 1'b1;
          if (cnt_ff == CNT_W'(`NMER_STROBE_CYC)) begin
            nxt_cnt = '0;
            if (op_ff == `NMER_OP_STATUS) begin
              nxt_result = dq_s2_ff;
              nxt_err    = dq_s2_ff[6] && dq_s2_ff[0];
              nxt_state  = NMER_S_DONE;
            end else begin
              nxt_id   = {id_ff[7:0], dq_s2_ff};
              nxt_byte = byte_ff + 1'b1;
              if (op_ff == `NMER_OP_ID2 || byte_ff == 2'h1) begin
                nxt_state = NMER_S_DONE;
              end
            end
          end
        end
        default: begin
          nxt_pins.ce_n = 1'b1;
          nxt_done  = 1'b1;
          nxt_state = NMER_S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_ff  <= NMER_S_POWER;
      pins_ff   <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1,
                     read_strobe_n: 1'b1, wp_n: 1'b0,
                     dq_out: 8'h00, dq_oe: 1'b0};
      cnt_ff    <= '0;
      op_ff     <= 3'h0;
      sel_ff    <= 4'h0;
      idx_ff    <= 2'h0;
      byte_ff   <= 2'h0;
      acnt_ff   <= 2'h0;
      step_ff   <= 2'h0;
      result_ff <= 8'h00;
      id_ff     <= 16'h0000;
      done_ff   <= 1'b0;
      err_ff    <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
    end else begin
      state_ff  <= nxt_state;
      pins_ff   <= nxt_pins;
      cnt_ff    <= nxt_cnt;
      op_ff     <= nxt_op;
      sel_ff    <= nxt_sel;
      idx_ff    <= nxt_idx;
      byte_ff   <= nxt_byte;
      acnt_ff   <= nxt_acnt;
      step_ff   <= nxt_step;
      result_ff <= nxt_result;
      id_ff     <= nxt_id;
      done_ff   <= nxt_done;
      err_ff    <= nxt_err;
      rdata_ff  <= nxt_rdata;
    end
  end

  assign rdata         = rdata_ff;
  assign ce_n          = pins_ff.ce_n;
  assign cle           = pins_ff.cle;
  assign ale           = pins_ff.ale;
  assign we_n          = pins_ff.we_n;
  assign read_strobe_n = pins_ff.read_strobe_n;
  assign wp_n          = pins_ff.wp_n;
  assign dq_out        = pins_ff.dq_out;
  assign dq_oe         = pins_ff.dq_oe;

  AST_PWR_WP: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    state_ff == NMER_S_POWER |-> !wp_n && ce_n)
    else $error("write protect released during power-up wait");
  AST_GO_AFTER_SETUP: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    cle && dq_out == `NMER_CMD_ERASE_GO |-> step_ff == 2'h1)
    else $error("erase confirm without address sets");
  AST_SETUP_ADDR: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    $fell(cle) && $past(dq_out) == `NMER_CMD_ERASE_SETUP
    && state_ff == NMER_S_ADDR |-> ##[1:20] ale)
    else $error("setup not followed by address");
  AST_ADDR_LATCH: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    $rose(we_n) && !cle |-> ale)
    else $error("address strobe closed without address latch");
  AST_BUSY_CMD: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    $fell(we_n) && cle && !rb_s2_ff |->
    dq_out inside {`NMER_CMD_STATUS1, `NMER_CMD_STATUS2,
                   `NMER_CMD_RESET})
    else $error("illegal command while busy");
  // Serial input is never issued, so no program can be cut short
  AST_DEFINED_CMD: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    cle && dq_oe |-> dq_out inside {8'h60, 8'hD0, 8'h70, 8'h71,
                                    8'hFF, 8'h90, 8'h91})
    else $error("undefined command code");
  AST_ONE_PER_DIST: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    state_ff == NMER_S_ADDR && nxt_state == NMER_S_NEXT |=>
    !sel_ff[$past(idx_ff)])
    else $error("district selected twice");
  AST_STRB_EXCL: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !(!we_n && !read_strobe_n))
    else $error("both flash strobes low");
  AST_RESULT: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    state_ff == NMER_S_READ && op_ff == `NMER_OP_STATUS
    && cnt_ff == CNT_W'(`NMER_STROBE_CYC) |=> result_ff == $past(dq_s2_ff))
    else $error("status byte not captured");
endmodule

/* File: verif/nmer_flash_model.sv */
// Behavioural flash device facing the host controller's pins
`timescale 1ns/1ps
module nmer_flash_model #(
  parameter logic [7:0] MAKER_ID = 8'hA5,  // Arbitrary value
  parameter logic [7:0] PART_ID  = 8'h3C,  // Arbitrary value
  parameter logic [7:0] EXT_ID   = 8'h4B   // Arbitrary value
) (
  input  wire logic        ce_n,          // Chip enable
  input  wire logic        cle,           // Command latch
  input  wire logic        ale,           // Address latch
  input  wire logic        we_n,          // Write strobe
  input  wire logic        read_strobe_n, // Read strobe
  input  wire logic        wp_n,          // Write protect
  input  wire logic [7:0]  dq_host,       // Data wire level
  input  wire logic [3:0]  fail_mask,     // Districts that fail
  input  wire logic [15:0] busy_ns,       // Erase duration
  output logic      [7:0]  dq_dev,        // Data driven by device
  output logic             ready_busy_n,  // Ready, low when busy
  output logic             proto_err,     // Host broke a rule
  output logic      [12:0] blk_xor,       // Xor of erased blocks
  output logic      [15:0] n_cmds         // Commands seen
);
  logic [7:0]  cmd   = 8'h00;
  logic [7:0]  rdq[$];
  logic [3:0]  used  = 4'h0;
  logic [3:0]  fails = 4'h0;
  logic [12:0] blk   = 13'h0000;
  int          na    = 0;
  int          gen   = 0;
  initial begin
    dq_dev = 8'hFF;
    ready_busy_n = 1'b1;
    proto_err = 1'b0;
    blk_xor = 13'h0000;
    n_cmds = 16'h0000;
  end
  // A newer erase confirm or reset bumps gen so a pending completion is dropped
  task automatic start_busy(input int t);
    gen = gen + 1;
    ready_busy_n = 1'b0;
    fork
      begin
        automatic int g = gen;
        #(t);
        if (g == gen) ready_busy_n = 1'b1;
      end
    join_none
  endtask
  always @(posedge we_n) begin
    if (!ce_n && cle) begin
      n_cmds = n_cmds + 16'h0001;
      if (!wp_n) proto_err = 1'b1;
      if (!ready_busy_n && !(dq_host inside {8'h70, 8'h71, 8'hFF}))
        proto_err = 1'b1;
      case (dq_host)
        8'h60: na = 0;
        8'hD0: begin
          if (used == 4'h0 || cmd != 8'h60) proto_err = 1'b1;
          fails = used & fail_mask;
          used = 4'h0;
          start_busy(busy_ns);
        end
        8'h70, 8'h71: rdq = {};
        8'hFF: begin
          fails = 4'h0;
          used = 4'h0;
          start_busy(50);
        end
        8'h90: rdq = '{MAKER_ID, PART_ID};
        8'h91: rdq = '{EXT_ID};
        // Serial input and program codes land here as protocol errors
        default: proto_err = 1'b1;
      endcase
      cmd = dq_host;
    end else if (!ce_n && ale && cmd == 8'h60) begin
      case (na)
        0: blk[2:0] = dq_host[7:5];
        1: blk[10:3] = dq_host;
        default: begin
          blk[12:11] = dq_host[1:0];
          if (used[blk[1:0]]) proto_err = 1'b1;
          used[blk[1:0]] = 1'b1;
          blk_xor = blk_xor ^ blk;
        end
      endcase
      na = na + 1;
    end
  end
  always @(negedge read_strobe_n) begin
    if (!ce_n) begin
      #8;
      if (cmd == 8'h70 || cmd == 8'h71)
        dq_dev = {wp_n, ready_busy_n, 1'b0,
                  ready_busy_n ? {fails, |fails} : 5'h00};
      else if (rdq.size() > 0)
        dq_dev = rdq.pop_front();
    end
  end
  // Released bus shows the inverse, never a held value
  always @(posedge read_strobe_n) begin
    // Off the host's clock edge so its sampling never races the change
    #7;
    dq_dev = ~dq_dev;
  end
endmodule

/* File: verif/nmer_host_tb_top.sv */
// Self-checking bench for the NAND multi-erase host controller
`timescale 1ns/1ps
`include "nmer_regs.svh"
module nmer_host_tb_top;
  localparam logic [7:0] MK = 8'hA5;  // Arbitrary value
  localparam logic [7:0] PT = 8'h3C;  // Arbitrary value
  localparam logic [7:0] EX = 8'h4B;  // Arbitrary value
  logic        clk_sys, rst_n, wr, rd, want, want_d;
  logic [3:0]  addr, fail_mask, sel, fm, f;
  logic [31:0] wdata, rdata;
  logic [7:0]  dq_out, dq_dev, dq_bus, ex;
  logic        ce_n, cle, ale, we_n, read_strobe_n, wp_n, dq_oe;
  logic        ready_busy_n, proto_err;
  logic [15:0] busy_ns, n_cmds, nc;
  logic [12:0] blk_xor, xr;
  logic [10:0] idx;
  logic [63:0] notes[$];
  logic [63:0] nt;
  logic [3:0]  sels [3] = '{4'h4, 4'hF, 4'h1};
  logic [31:0] bad [4] = '{32'h1, 32'h0, 32'h6, 32'h7};
  int          n_fail = 0;
  int          check_count = 0;
  assign dq_bus = dq_oe ? dq_out : dq_dev;
  nmer_host u_nmer_host (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .dq_in(dq_bus),
    .ready_busy_n(ready_busy_n), .ce_n(ce_n), .cle(cle), .ale(ale),
    .we_n(we_n), .read_strobe_n(read_strobe_n), .wp_n(wp_n),
    .dq_out(dq_out), .dq_oe(dq_oe));
  nmer_flash_model #(.MAKER_ID(MK), .PART_ID(PT), .EXT_ID(EX))
    u_nmer_flash_model (.ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
    .read_strobe_n(read_strobe_n), .wp_n(wp_n), .dq_host(dq_bus),
    .fail_mask(fail_mask), .busy_ns(busy_ns), .dq_dev(dq_dev),
    .ready_busy_n(ready_busy_n), .proto_err(proto_err),
    .blk_xor(blk_xor), .n_cmds(n_cmds));
  always #5 clk_sys = ~clk_sys;
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Read data stand only in the cycle after the strobe
  always @(posedge clk_sys) begin
    want_d <= want;
    if (want_d) begin
      nt = notes.pop_front();
      check("rdata", rdata & nt[63:32], nt[31:0]);
    end
  end
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
    // One idle edge, so no strobe is written twice in one time step
    @(posedge clk_sys);
  endtask
  task automatic rreg(input logic [3:0] a, input logic [31:0] e,
                      input logic [31:0] m);
    notes.push_back({m, e & m});
    addr <= a;
    rd <= 1'b1;
    want <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    want <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wait_done();
    int k;
    k = 0;
    do begin
      addr <= `NMER_OFF_STAT;
      rd <= 1'b1;
      @(posedge clk_sys);
      rd <= 1'b0;
      @(posedge clk_sys);
      k++;
    end while (rdata[2:0] !== 3'b110 && k < 5000);
    if (k >= 5000) begin
      n_fail++;
      $display("BAD done expected 1 seen 0");
      wrap_up();
    end
  endtask
  initial begin
    clk_sys = 1'b0;
    rst_n = 1'b0;
    {addr, wdata, wr, rd, want, fail_mask} = '0;
    busy_ns = 16'd300;
    xr = 13'h0000;
    void'($urandom(16));
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    wreg(`NMER_OFF_CTRL, 32'h2);
    repeat (100) @(posedge clk_sys);
    check("wp_n", {31'h0, wp_n}, 32'h0);
    check("ce_n", {31'h0, ce_n}, 32'h1);
    repeat (20000) @(posedge clk_sys);
    rreg(`NMER_OFF_STAT, 32'h0, 32'h4);
    rreg(4'hF, 32'h0, 32'hFFFFFFFF);
    for (int i = 0; i < 6; i++) begin
      sel = (i < 3) ? sels[i] : 4'($urandom_range(15, 1));
      fm = 4'($urandom);
      fail_mask <= fm;
      for (int d = 0; d < 4; d++) begin
        idx = 11'($urandom);
        if (sel[d]) xr = xr ^ {idx, 2'(d)};
        wreg(`NMER_OFF_BLK0 + 4'(d), {21'h0, idx});
      end
      wreg(`NMER_OFF_CTRL, {25'h0, sel, `NMER_OP_ERASE});
      wait_done();
      f = sel & fm;
      ex = {3'b110, f, |f};
      rreg(`NMER_OFF_RESULT, {24'h0, ex}, 32'hDF);
      rreg(`NMER_OFF_STAT, {28'h0, |f, 3'b110}, 32'hF);
      check("blk_xor", {19'h0, blk_xor}, {19'h0, xr});
    end
    foreach (bad[j]) begin
      nc = n_cmds;
      wreg(`NMER_OFF_CTRL, bad[j]);
      repeat (20) @(posedge clk_sys);
      rreg(`NMER_OFF_STAT, 32'h8, 32'h8);
      check("n_cmds", {16'h0, n_cmds}, {16'h0, nc});
    end
    busy_ns <= 16'd20000;
    fail_mask <= 4'hF;
    wreg(`NMER_OFF_CTRL, {25'h0, 4'hF, `NMER_OP_ERASE});
    repeat (400) @(posedge clk_sys);
    wreg(`NMER_OFF_CTRL, {29'h0, `NMER_OP_ID1});
    wreg(`NMER_OFF_CTRL, {29'h0, `NMER_OP_RESET});
    wait_done();
    rreg(`NMER_OFF_RESULT, 32'hC0, 32'hDF);
    busy_ns <= 16'd300;
    wreg(`NMER_OFF_CTRL, {29'h0, `NMER_OP_STATUS});
    wait_done();
    rreg(`NMER_OFF_RESULT, 32'hC0, 32'hDF);
    wreg(`NMER_OFF_CTRL, {29'h0, `NMER_OP_ID1});
    wait_done();
    rreg(`NMER_OFF_ID, {16'h0, MK, PT}, 32'hFFFF);
    wreg(`NMER_OFF_CTRL, {29'h0, `NMER_OP_ID2});
    wait_done();
    rreg(`NMER_OFF_ID, {24'h0, EX}, 32'hFF);
    repeat (3) @(posedge clk_sys);
    check("proto_err", {31'h0, proto_err}, 32'h0);
    wrap_up();
  end
endmodule
